//--- bench/sasr_host.sv
`timescale 1ns/1ps
module sasr_host(
	output logic cs_n,
	output logic sck,
	input wire logic dout,
	input wire logic dout_oe_n
);
	logic line;
	// Released line shows the inverse, so a stale bit never passes
	assign line = dout_oe_n ? ~dout : dout;
	initial begin
		cs_n = 1'b1;
		sck = 1'b1;
	end
	task automatic xfer(output logic [16:0] w, output logic [16:0] wr);
		cs_n = 1'b0;
		#600;
		// Sampled at the fall: each bit holds from the previous fall
		for (int i = 0; i < 22; i++) begin
			w = {w[15:0], line};
			sck = 1'b0;
			#100;
			// Rising-edge capture of the same bit; the last fall only shifts filler
			if (i < 21) wr = {wr[15:0], line};
			sck = 1'b1;
			#100;
		end
		#100 cs_n = 1'b1;
	endtask
endmodule

//--- bench/sasr_readout_properties.sv
`timescale 1ns/1ps
module sasr_chk
	import sasr_pkg::*;
(
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic CS_N,
	input wire logic SERIAL_SHIFT_CLOCK,
	input wire logic DOUT,
	input wire logic DOUT_OE_N,
	input wire logic POWERED_UP,
	input wire logic CONV_BUSY
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (SRST);
	a_busy_len: assert property ($rose(CONV_BUSY) |-> ##15 CONV_BUSY ##1 !CONV_BUSY)
		else $error("busy length");
	a_power_same: assert property (POWERED_UP == CONV_BUSY) else $error("power");
	a_busy_start: assert property ($fell(CS_N) |-> ##[2:6] $rose(CONV_BUSY))
		else $error("no start");
	a_oe_late: assert property ($rose(CONV_BUSY) |-> DOUT_OE_N [*8]) else $error("early");
	a_lead_low: assert property ($fell(DOUT_OE_N) |-> !DOUT) else $error("lead");
	a_oe_sel: assert property ($fell(DOUT_OE_N) |-> !CS_N) else $error("oe sel");
	a_oe_off: assert property (CS_N [*6] |-> DOUT_OE_N) else $error("oe off");
	a_bit_hold: assert property (!CS_N && $rose(SERIAL_SHIFT_CLOCK) |-> ##1 $stable(DOUT) [*5])
		else $error("bit hold");
endmodule
bind sasr_readout sasr_chk u_chk(.CLOCK(CLOCK), .SRST(SRST), .CS_N(CS_N),
	.SERIAL_SHIFT_CLOCK(SERIAL_SHIFT_CLOCK), .DOUT(DOUT), .DOUT_OE_N(DOUT_OE_N),
	.POWERED_UP(POWERED_UP), .CONV_BUSY(CONV_BUSY));

//--- bench/test_sasr_readout.sv
`timescale 1ns/1ps
module test_sasr_readout;
	logic clock, srst, cs_n, sck, dout, dout_oe_n, powered_up, conv_busy;
	logic [17:0] sample;
	int error_cnt = 0;
	int num_checks = 0;
	sasr_readout DUT(.CLOCK(clock), .SRST(srst), .CS_N(cs_n), .SERIAL_SHIFT_CLOCK(sck),
		.ANALOG_SAMPLE(sample), .DOUT(dout), .DOUT_OE_N(dout_oe_n),
		.POWERED_UP(powered_up), .CONV_BUSY(conv_busy));
	sasr_host HOST(.cs_n(cs_n), .sck(sck), .dout(dout), .dout_oe_n(dout_oe_n));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic chk(string n, logic [16:0] e, logic [16:0] s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic conclude;
		$display("errors %0d checks %0d", error_cnt, num_checks);
		if (error_cnt == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic t_code(logic [17:0] a, logic [15:0] e);
		logic [16:0] w;
		logic [16:0] wr;
		@(negedge clock) sample = a;
		HOST.xfer(w, wr);
		chk("word", {1'b0, e}, w);
		chk("word_rise", {1'b0, e}, wr);
		repeat (8) @(negedge clock);
		chk("idle", 17'h1, {16'h0, dout_oe_n & ~conv_busy & ~powered_up});
	endtask
	initial begin
		srst = 1'b1;
		sample = 18'h0;
		repeat (20) @(negedge clock);
		srst = 1'b0;
		t_code(18'h00000, 16'h0000);
		t_code(18'h00001, 16'h0001);
		t_code(18'h3FFFF, 16'hFFFF);
		t_code(18'h07FFF, 16'h7FFF);
		t_code(18'h08000, 16'h7FFF);
		t_code(18'h1FFFF, 16'h7FFF);
		t_code(18'h38000, 16'h8000);
		t_code(18'h37FFF, 16'h8000);
		t_code(18'h20000, 16'h8000);
		conclude;
	end
	initial begin
		#200000;
		error_cnt++;
		conclude;
	end
endmodule

//--- hw/sasr_pkg.sv
package sasr_pkg;
	localparam int SASR_RES_W = 16;
	localparam int SASR_LEAD_EDGES = 5;
	localparam int SASR_EDGE_CNT_W = 5;
	localparam logic [15:0] SASR_CODE_MAX = 16'h7FFF;
	localparam logic [15:0] SASR_CODE_MIN = 16'h8000;
	localparam int SASR_SAMPLE_W = 18;
	localparam int SASR_CONV_CYCLES = 16;
	localparam logic [4:0] SASR_CONV_CNT_W1 = 5'h10;

	typedef enum {SASR_IDLE, SASR_CONVERT, SASR_SHIFT} sasr_state_e;

	typedef struct packed {
		logic data;
		logic oe_n;
	} sasr_dout_s;
endpackage

//--- hw/sasr_readout.sv
`timescale 1ns/1ps
// Operation
// - Result is 16-bit two's complement word
// - Overrange input saturates to 7FFF
// - Underrange input saturates to 8000
// - Power down automatically after each conversion
// - Select falling edge starts conversion and transfer
// - After fifth falling edge drive output low
// - Then result bits MSB first per edge
// - Each bit valid across next both edges
// - Select high keeps output high impedance
module sasr_readout
	import sasr_pkg::*;
(
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic CS_N,
	input wire logic SERIAL_SHIFT_CLOCK,
	input wire logic signed [SASR_SAMPLE_W-1:0] ANALOG_SAMPLE,
	output logic DOUT,
	output logic DOUT_OE_N,
	output logic POWERED_UP,
	output logic CONV_BUSY
);
	// Three-stage synchronisers; the first stage feeds only the second
	logic [2:0] cs_sync_reg;
	logic [2:0] sck_sync_reg;
	logic cs_level_reg;
	logic sck_level_reg;
	sasr_state_e state_reg;
	logic [SASR_EDGE_CNT_W-1:0] edge_cnt_reg;
	logic [4:0] conv_cnt_reg;
	logic [SASR_RES_W-1:0] result_reg;
	logic [SASR_RES_W-1:0] shift_reg;
	sasr_dout_s dout_reg;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			cs_sync_reg <= 3'h7;
			sck_sync_reg <= 3'h0;
		end else begin
			cs_sync_reg <= {cs_sync_reg[1:0], CS_N};
			sck_sync_reg <= {sck_sync_reg[1:0], SERIAL_SHIFT_CLOCK};
		end
	end

	// A change counts only once stages two and three agree
	wire cs_agree = (cs_sync_reg[1] == cs_sync_reg[2]);
	wire sck_agree = (sck_sync_reg[1] == sck_sync_reg[2]);
	wire cs_level_next = cs_agree ? cs_sync_reg[2] : cs_level_reg;
	wire sck_level_next = sck_agree ? sck_sync_reg[2] : sck_level_reg;
	wire cs_fall = cs_level_reg & ~cs_level_next;
	wire cs_high = cs_level_next;
	wire sck_fall = sck_level_reg & ~sck_level_next;

	// Saturating clamp of the signed sample into 16 bits
	function automatic logic [SASR_RES_W-1:0] sasr_clamp(input logic signed [SASR_SAMPLE_W-1:0] s);
		logic signed [SASR_SAMPLE_W-1:0] hi;
		logic signed [SASR_SAMPLE_W-1:0] lo;
		hi = SASR_SAMPLE_W'(signed'({1'b0, SASR_CODE_MAX}));
		lo = -hi - SASR_SAMPLE_W'(1);
		if (s > hi)
			return SASR_CODE_MAX;
		else if (s < lo)
			return SASR_CODE_MIN;
		else
			return s[SASR_RES_W-1:0];
	endfunction

	wire [SASR_RES_W-1:0] clamped = sasr_clamp(ANALOG_SAMPLE);
	wire conv_done = (state_reg == SASR_CONVERT) && (conv_cnt_reg == SASR_CONV_CNT_W1 - 5'h01);
	wire lead_done = (edge_cnt_reg == SASR_EDGE_CNT_W'(SASR_LEAD_EDGES));

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			cs_level_reg <= 1'b1;
			sck_level_reg <= 1'b0;
		end else begin
			cs_level_reg <= cs_level_next;
			sck_level_reg <= sck_level_next;
		end
	end

	// Conversion timing is internal and independent of the shift clock
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			state_reg <= SASR_IDLE;
			conv_cnt_reg <= 5'h00;
			result_reg <= 16'h0000;
		end else if (cs_fall) begin
			state_reg <= SASR_CONVERT;
			conv_cnt_reg <= 5'h00;
			result_reg <= clamped;
		end else if (conv_done) begin
			state_reg <= SASR_IDLE;
		end else if (state_reg == SASR_CONVERT) begin
			conv_cnt_reg <= conv_cnt_reg + 5'h01;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST || cs_high) begin
			edge_cnt_reg <= '0;
			shift_reg <= 16'h0000;
			dout_reg <= '{data: 1'b0, oe_n: 1'b1};
		end else if (cs_fall) begin
			edge_cnt_reg <= '0;
			dout_reg <= '{data: 1'b0, oe_n: 1'b1};
		end else if (sck_fall) begin
			if (!lead_done)
				edge_cnt_reg <= edge_cnt_reg + SASR_EDGE_CNT_W'(1);
			if (edge_cnt_reg == SASR_EDGE_CNT_W'(SASR_LEAD_EDGES - 1)) begin
				dout_reg <= '{data: 1'b0, oe_n: 1'b0};
				shift_reg <= result_reg;
			end else if (lead_done) begin
				// Bit stays until the next falling edge
				dout_reg.data <= shift_reg[SASR_RES_W-1];
				shift_reg <= {shift_reg[SASR_RES_W-2:0], 1'b0};
			end
		end
	end

	assign DOUT = dout_reg.data;
	assign DOUT_OE_N = dout_reg.oe_n;
	assign CONV_BUSY = (state_reg == SASR_CONVERT);
	assign POWERED_UP = (state_reg == SASR_CONVERT);
endmodule
